// file: rtl/pmsd_drive_sequencer.sv
// Purpose: Drive sequencer, modulation master, brake, speed loop and resolver observer.
// Assumes: AHB-Lite slave with zero wait states; filtered samples arrive synchronous.
// Notes: Read data is captured in the address phase.
`timescale 1ns/1ps
`include "pmsd_params.svh"
module pmsd_drive_sequencer
  import pmsd_pkg::*;
#(
  parameter int unsigned EXC_CYCLES = `PMSD_EXC_CYC,
  parameter logic signed [15:0] SPEED_RANGE = `PMSD_SPEED_RANGE
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic signed [15:0] i_ifilt_a,
  input wire logic signed [15:0] i_ifilt_b,
  input wire logic signed [15:0] i_ifilt_c,
  input wire logic [15:0] i_udc_filt,
  input wire logic signed [15:0] i_vcc_uq,
  input wire logic signed [15:0] i_iq_act,
  input wire logic i_d_sat,
  input wire logic i_q_sat,
  input wire logic i_dma_we,
  input wire logic i_dma_addr,
  input wire logic signed [15:0] i_dma_data,
  input wire logic i_dma_done,
  output logic [2:0] o_pwm_hi,
  output logic [2:0] o_pwm_lo,
  output logic o_brake,
  output logic o_excite,
  output logic o_adc_trig,
  output logic o_vcc_run,
  output logic signed [15:0] o_torque_dem
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic signed [15:0] pmsd_sin(input logic [15:0] a);
    logic [3:0] i;
    logic [15:0] t;
    i = a[14] ? ~a[13:10] : a[13:10];
    case (i)
      4'h0: t = 16'h0648; 4'h1: t = 16'h12c8; 4'h2: t = 16'h1f1a; 4'h3: t = 16'h2b1f;
      4'h4: t = 16'h36ba; 4'h5: t = 16'h41ce; 4'h6: t = 16'h4c40; 4'h7: t = 16'h55f6;
      4'h8: t = 16'h5ed7; 4'h9: t = 16'h66cf; 4'ha: t = 16'h6dc9; 4'hb: t = 16'h73b5;
      4'hc: t = 16'h7885; 4'hd: t = 16'h7c29; 4'he: t = 16'h7e9d; default: t = 16'h7fd8;
    endcase
    return a[15] ? -$signed(t) : $signed(t);
  endfunction

  function automatic logic signed [16:0] pmsd_mul(input logic signed [15:0] x, input logic signed [15:0] y);
    logic signed [31:0] p;
    p = (32'(x) * 32'(y)) >>> 15;
    return 17'(p);
  endfunction

  function automatic logic [15:0] pmsd_pct(input logic [15:0] u, input logic [7:0] p);
    logic [23:0] m;
    m = (24'(u) * 24'(p)) / 24'h000064;
    return (m > 24'h00ffff) ? 16'hffff : m[15:0];
  endfunction

  function automatic logic [11:0] pmsd_duty(input logic signed [17:0] v);
    logic signed [31:0] p;
    p = ((32'(v) * 32'(`PMSD_PWM_CYC)) >>> 16) + 32'(`PMSD_PWM_CYC / 2);
    if (p < 0) return 12'h000;
    if (p > 32'(`PMSD_PWM_CYC)) return 12'(`PMSD_PWM_CYC);
    return 12'(p);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  pmsd_state_type st_q, st_d;
  logic wr_q, wr_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] hrdata_q, hrdata_d, rsel;
  logic [23:0] ud_q, ud_d;
  logic signed [15:0] req_q, req_d;
  logic [15:0] pct_q, pct_d, exsh_q, exsh_d;
  logic [16:0] cfg_q, cfg_d;
  logic closed_q, closed_d;
  logic signed [15:0] offa_q, offa_d, offb_q, offb_d, offc_q, offc_d;
  logic [15:0] thon_q, thon_d, thoff_q, thoff_d, roff_q, roff_d;
  logic bren_q, bren_d, brake_q, brake_d;
  logic [7:0] sccnt_q, sccnt_d;
  logic signed [15:0] torq_q, torq_d;
  logic scsat_q, scsat_d;
  logic take, cmd_wr, sc_tick, pwm_wrap;
  logic [2:0] cmd;
  logic signed [15:0] req_frac;
  logic signed [31:0] sc_p;
  logic signed [15:0] fb_mem [0:1];
  logic [11:0] pwm_q, pwm_d;
  logic [11:0] duty_q [0:2];
  logic [11:0] duty_d [0:2];
  logic [15:0] exc_q, exc_d, theta_q, theta_d, revs_q, revs_d, ang0, exc_t;
  logic signed [15:0] speed_q, speed_d, amp;
  logic signed [16:0] v [0:2];
  logic signed [16:0] vmx, vmn, cm, err;
  logic signed [17:0] step, tnext;
  logic pwm_run;

  assign take = i_hsel && i_htrans[1] && i_hready;
  assign cmd_wr = wr_q && waddr_q == `PMSD_A_CMD;
  assign cmd = i_hwdata[2:0];
  assign req_frac = 16'((32'(req_q) * 32'sh00007fff) / 32'(SPEED_RANGE));

  always_comb begin
    rsel = 32'h0000_0000;
    case (i_haddr[7:0])
      `PMSD_A_ALIGN_UD: rsel = {8'h00, ud_q};
      `PMSD_A_SPEED_REQ: rsel = {16'h0000, req_q};
      `PMSD_A_BRAKE_PCT: rsel = {16'h0000, pct_q};
      `PMSD_A_CONFIG: rsel = {15'h0000, cfg_q};
      `PMSD_A_EXC_SHIFT: rsel = {16'h0000, exsh_q};
      `PMSD_A_STATUS: rsel = {23'h000000, brake_q, i_q_sat, i_d_sat, scsat_q, speed_q[15], closed_q, st_q};
      `PMSD_A_SPEED_ACT: rsel = {16'h0000, speed_q};
      `PMSD_A_TORQUE: rsel = {i_iq_act, torq_q};
      `PMSD_A_VOLT: rsel = {16'h0000, amp};
      `PMSD_A_REVS: rsel = {16'h0000, revs_q};
      `PMSD_A_OFFS_AB: rsel = {offb_q, offa_q};
      `PMSD_A_OFFS_C: rsel = {16'h0000, offc_q};
      `PMSD_A_BRAKE_TH: rsel = {thoff_q, thon_q};
      `PMSD_A_RSLV_OFF: rsel = {16'h0000, roff_q};
      default: rsel = 32'h0000_0000;
    endcase
  end

  always_comb begin
    wr_d = take && i_hwrite;
    waddr_d = take ? i_haddr[7:0] : waddr_q;
    hrdata_d = (take && !i_hwrite) ? rsel : hrdata_q;
    st_d = st_q;
    ud_d = ud_q;
    req_d = req_q;
    pct_d = pct_q;
    cfg_d = cfg_q;
    exsh_d = exsh_q;
    closed_d = closed_q;
    offa_d = offa_q;
    offb_d = offb_q;
    offc_d = offc_q;
    thon_d = thon_q;
    thoff_d = thoff_q;
    roff_d = roff_q;
    bren_d = bren_q;
    if (wr_q) begin
      case (waddr_q)
        `PMSD_A_ALIGN_UD: ud_d = i_hwdata[23:0];
        `PMSD_A_SPEED_REQ: req_d = i_hwdata[15:0];
        `PMSD_A_BRAKE_PCT: pct_d = i_hwdata[15:0];
        `PMSD_A_CONFIG: cfg_d = i_hwdata[16:0];
        `PMSD_A_EXC_SHIFT: exsh_d = i_hwdata[15:0];
        default: ;
      endcase
    end
    if (cmd_wr) begin
      case (cmd)
        `PMSD_CMD_CAL_START: if (st_q == ST_DIS || st_q == ST_CALDONE) st_d = ST_CAL;
        `PMSD_CMD_CAL_FIN: if (st_q == ST_CAL) begin
          st_d = ST_CALDONE;
          offa_d = i_ifilt_a;
          offb_d = i_ifilt_b;
          offc_d = i_ifilt_c;
          thon_d = pmsd_pct(i_udc_filt, pct_q[7:0]);
          thoff_d = pmsd_pct(i_udc_filt, pct_q[15:8]);
          bren_d = 1'b1;
        end
        `PMSD_CMD_ALIGN_START: if (st_q == ST_CALDONE) st_d = ST_ALIGN;
        `PMSD_CMD_ALIGN_FIN: if (st_q == ST_ALIGN) begin
          st_d = ST_RUN;
          roff_d = theta_q;
          closed_d = i_hwdata[`PMSD_CMD_LOOP_BIT];
        end
        `PMSD_CMD_DISABLE: st_d = ST_DIS;
        default: ;
      endcase
    end
  end

  // The speed loop ticks on whole PWM periods only; a divider of zero acts as one.
  always_comb begin
    sc_tick = pwm_wrap && (sccnt_q + 8'h01 >= cfg_q[7:0]);
    sccnt_d = pwm_wrap ? (sc_tick ? 8'h00 : sccnt_q + 8'h01) : sccnt_q;
    torq_d = torq_q;
    scsat_d = scsat_q;
    sc_p = ((32'(req_frac) - 32'(speed_q)) * 32'(signed'({1'b0, cfg_q[15:8]}))) >>> 4;
    if (st_q != ST_RUN) begin
      torq_d = 16'h0000;
      scsat_d = 1'b0;
    end else if (sc_tick && !closed_q) begin
      torq_d = req_frac;
      scsat_d = 1'b0;
    end else if (sc_tick) begin
      scsat_d = sc_p > 32'sh00007fff || sc_p < -32'sh00007fff;
      torq_d = (sc_p > 32'sh00007fff) ? 16'h7fff : (sc_p < -32'sh00007fff) ? 16'h8001 : 16'(sc_p);
    end
    brake_d = brake_q;
    if (!bren_q) brake_d = 1'b0;
    else if (i_udc_filt > thon_q) brake_d = 1'b1;
    else if (i_udc_filt < thoff_q) brake_d = 1'b0;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q <= ST_DIS;
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      ud_q <= 24'h000000;
      req_q <= 16'h0000;
      pct_q <= {`PMSD_RST_BRAKE_OFF, `PMSD_RST_BRAKE_ON};
      cfg_q <= {1'b0, `PMSD_RST_KP, `PMSD_RST_SC_DIV};
      exsh_q <= 16'h0000;
      closed_q <= 1'b0;
      offa_q <= 16'h0000;
      offb_q <= 16'h0000;
      offc_q <= 16'h0000;
      thon_q <= 16'h0000;
      thoff_q <= 16'h0000;
      roff_q <= 16'h0000;
      bren_q <= 1'b0;
      brake_q <= 1'b0;
      sccnt_q <= 8'h00;
      torq_q <= 16'h0000;
      scsat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wr_q <= wr_d;
      waddr_q <= waddr_d;
      hrdata_q <= hrdata_d;
      ud_q <= ud_d;
      req_q <= req_d;
      pct_q <= pct_d;
      cfg_q <= cfg_d;
      exsh_q <= exsh_d;
      closed_q <= closed_d;
      offa_q <= offa_d;
      offb_q <= offb_d;
      offc_q <= offc_d;
      thon_q <= thon_d;
      thoff_q <= thoff_d;
      roff_q <= roff_d;
      bren_q <= bren_d;
      brake_q <= brake_d;
      sccnt_q <= sccnt_d;
      torq_q <= torq_d;
      scsat_q <= scsat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_core_clk) begin
    if (i_dma_we) fb_mem[i_dma_addr] <= i_dma_data;
  end

  always_comb begin
    pwm_run = st_q == ST_ALIGN || st_q == ST_RUN;
    pwm_wrap = pwm_q == 12'(`PMSD_PWM_CYC - 1);
    pwm_d = pwm_wrap ? 12'h000 : pwm_q + 12'h001;
    ang0 = (st_q == ST_ALIGN) ? 16'h0000 : theta_q - roff_q + `PMSD_QUARTER;
    amp = (st_q == ST_ALIGN) ? ud_q[23:8] : i_vcc_uq;
    for (int k = 0; k < 3; k++) begin
      v[k] = pmsd_mul(amp, pmsd_sin(ang0 - 16'(k * `PMSD_PHASE_STEP) + `PMSD_QUARTER));
    end
    vmx = v[0];
    vmn = v[0];
    for (int k = 1; k < 3; k++) begin
      if (v[k] > vmx) vmx = v[k];
      if (v[k] < vmn) vmn = v[k];
    end
    cm = cfg_q[`PMSD_CFG_SVM_BIT] ? 17'((18'(vmx) + 18'(vmn)) >>> 1) : 17'sh00000;
    // Duties change only at the period boundary so a phase never sees a torn update.
    for (int k = 0; k < 3; k++) begin
      duty_d[k] = pwm_wrap ? pmsd_duty(18'(v[k]) - 18'(cm)) : duty_q[k];
    end
    exc_d = (32'(exc_q) >= EXC_CYCLES - 1) ? 16'h0000 : exc_q + 16'h0001;
    exc_t = (exc_q >= exsh_q) ? exc_q - exsh_q : 16'(32'(exc_q) + EXC_CYCLES - 32'(exsh_q));
    err = pmsd_mul(fb_mem[0], pmsd_sin(theta_q + `PMSD_QUARTER)) - pmsd_mul(fb_mem[1], pmsd_sin(theta_q));
    step = 18'(speed_q) + 18'(err >>> `PMSD_OBS_K2);
    tnext = 18'({2'b00, theta_q}) + step;
    speed_d = speed_q;
    theta_d = theta_q;
    revs_d = revs_q;
    if (i_dma_done) begin
      speed_d = speed_q + 16'(err >>> `PMSD_OBS_K1);
      theta_d = tnext[15:0];
      if (tnext[17]) revs_d = revs_q - 16'h0001;
      else if (tnext[16]) revs_d = revs_q + 16'h0001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pwm_q <= 12'h000;
      exc_q <= 16'h0000;
      theta_q <= 16'h0000;
      speed_q <= 16'h0000;
      revs_q <= 16'h0000;
      o_excite <= 1'b0;
      o_adc_trig <= 1'b0;
      for (int k = 0; k < 3; k++) duty_q[k] <= 12'h000;
    end else begin
      pwm_q <= pwm_d;
      exc_q <= exc_d;
      theta_q <= theta_d;
      speed_q <= speed_d;
      revs_q <= revs_d;
      o_excite <= 32'(exc_t) < EXC_CYCLES / 2;
      o_adc_trig <= exc_q == 16'h0000;
      for (int k = 0; k < 3; k++) duty_q[k] <= duty_d[k];
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_ph
    pmsd_phase_gen u_ph (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_cnt(pwm_q),
      .i_duty(duty_q[g]),
      .i_run(pwm_run),
      .i_cal(st_q == ST_CAL),
      .o_hi(o_pwm_hi[g]),
      .o_lo(o_pwm_lo[g])
    );
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_q;
  assign o_brake = brake_q;
  assign o_vcc_run = st_q == ST_RUN;
  assign o_torque_dem = torq_q;

  ////////////////////////////////////////////////////////////////////////////////
  a_cal_force: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    st_q == ST_CAL && $past(st_q) == ST_CAL |-> o_pwm_hi == 3'b000 && o_pwm_lo == 3'b111)
    else $error("calibration outputs wrong");
  a_cal_offs: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_wr && cmd == `PMSD_CMD_CAL_FIN && st_q == ST_CAL |=> offa_q == $past(i_ifilt_a) && st_q == ST_CALDONE)
    else $error("offset not stored");
  a_brake_th: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_wr && cmd == `PMSD_CMD_CAL_FIN && st_q == ST_CAL |=> thon_q == pmsd_pct($past(i_udc_filt), pct_q[7:0]))
    else $error("brake threshold wrong");
  a_align_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    st_q == ST_ALIGN && pwm_wrap && !ud_q[23] |=> duty_q[0] >= duty_q[1] && duty_q[0] >= duty_q[2])
    else $error("alignment vector wrong");
  a_align_fin: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_wr && cmd == `PMSD_CMD_ALIGN_FIN && st_q == ST_ALIGN |=> st_q == ST_RUN && roff_q == $past(theta_q))
    else $error("alignment finish wrong");
  a_disable_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_wr && cmd == `PMSD_CMD_DISABLE |=> st_q == ST_DIS && !o_vcc_run ##1 o_pwm_hi == 3'b000 && o_pwm_lo == 3'b000)
    else $error("disable did not stop drive");
  a_open_loop: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    st_q == ST_RUN && st_d == ST_RUN && !closed_q && sc_tick |=> torq_q == $past(req_frac))
    else $error("open loop torque wrong");
  a_brake_hyst: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    bren_q && i_udc_filt > thon_q |=> o_brake)
    else $error("brake not on above threshold");
  a_cmd_order: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    cmd_wr && cmd == `PMSD_CMD_ALIGN_START && st_q == ST_DIS |=> st_q == ST_DIS)
    else $error("out of order command accepted");
endmodule

// file: rtl/pmsd_params.svh
// Purpose: Offsets, field positions, reset values and timing counts for the drive sequencer.
// Assumes: 250 MHz core clock, byte addresses on AHB-Lite, one aligned word per register.
// Notes: Included by the sequencer and phase generator files of the block.
`ifndef PMSD_PARAMS_SVH
`define PMSD_PARAMS_SVH
`define PMSD_A_CMD 8'h00
`define PMSD_A_ALIGN_UD 8'h04
`define PMSD_A_SPEED_REQ 8'h08
`define PMSD_A_BRAKE_PCT 8'h0c
`define PMSD_A_CONFIG 8'h10
`define PMSD_A_EXC_SHIFT 8'h14
`define PMSD_A_STATUS 8'h18
`define PMSD_A_SPEED_ACT 8'h1c
`define PMSD_A_TORQUE 8'h20
`define PMSD_A_VOLT 8'h24
`define PMSD_A_REVS 8'h28
`define PMSD_A_OFFS_AB 8'h2c
`define PMSD_A_OFFS_C 8'h30
`define PMSD_A_BRAKE_TH 8'h34
`define PMSD_A_RSLV_OFF 8'h38
`define PMSD_CMD_CAL_START 3'h1
`define PMSD_CMD_CAL_FIN 3'h2
`define PMSD_CMD_ALIGN_START 3'h3
`define PMSD_CMD_ALIGN_FIN 3'h4
`define PMSD_CMD_DISABLE 3'h5
`define PMSD_CMD_LOOP_BIT 8
`define PMSD_CFG_SVM_BIT 16
`define PMSD_RST_BRAKE_ON 8'h82
`define PMSD_RST_BRAKE_OFF 8'h6e
`define PMSD_RST_SC_DIV 8'h01
`define PMSD_RST_KP 8'h10
`define PMSD_CLK_NS 4
`define PMSD_PWM_NS 10000
`define PMSD_PWM_CYC (`PMSD_PWM_NS / `PMSD_CLK_NS)
`define PMSD_EXC_NS 100000
`define PMSD_EXC_CYC (`PMSD_EXC_NS / `PMSD_CLK_NS)
`define PMSD_SPEED_RANGE 16'h1770
`define PMSD_OBS_K1 6
`define PMSD_OBS_K2 2
`define PMSD_PHASE_STEP 16'h5555
`define PMSD_QUARTER 16'h4000
`endif

// file: rtl/pmsd_pkg.sv
// Purpose: Types shared by the drive sequencer files.
// Assumes: Nothing beyond the parameter header.
// Notes: States carry no explicit codes.
package pmsd_pkg;
  typedef enum logic [2:0] {ST_DIS, ST_CAL, ST_CALDONE, ST_ALIGN, ST_RUN} pmsd_state_type;
endpackage

// file: rtl/pmsd_phase_gen.sv
// Purpose: Full-range phase generator for one PWM phase pair.
// Assumes: Shared period counter from the modulation master.
// Notes: No dead time is inserted; the power stage must add it.
`timescale 1ns/1ps
`include "pmsd_params.svh"
module pmsd_phase_gen
  import pmsd_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [11:0] i_cnt,
  input wire logic [11:0] i_duty,
  input wire logic i_run,
  input wire logic i_cal,
  output logic o_hi,
  output logic o_lo
);
  logic hi_d;
  logic lo_d;
  logic on_w;

  // A duty of zero never matches and a duty of one full period always does.
  always_comb begin
    on_w = i_cnt < i_duty;
    hi_d = i_run && on_w;
    lo_d = i_run ? !on_w : i_cal;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_hi <= 1'b0;
      o_lo <= 1'b0;
    end else begin
      o_hi <= hi_d;
      o_lo <= lo_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_full_on: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_run && i_duty == 12'(`PMSD_PWM_CYC) |=> o_hi && !o_lo)
    else $error("full duty not fully on");
  a_full_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_run && i_duty == 12'h000 |=> !o_hi && o_lo)
    else $error("zero duty not fully off");
endmodule

// file: sim/pmsd_resolver_model.sv
// Purpose: Resolver feedback path model, converter plus DMA into the observer memory.
// Assumes: One sine and one cosine sample per excitation trigger.
// Notes: DELAY sets how slowly samples arrive; the data line is scrambled when idle.
`timescale 1ns/1ps
module pmsd_resolver_model #(
  parameter int DELAY = 3
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_adc_trig,
  input wire logic signed [15:0] i_sin,
  input wire logic signed [15:0] i_cos,
  output logic o_dma_we,
  output logic o_dma_addr,
  output logic signed [15:0] o_dma_data,
  output logic o_dma_done
);
  int cnt;
  // Idle data is inverted each cycle so a stale sample is never mistaken for a fresh one.
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt <= 0;
      o_dma_we <= 1'b0;
      o_dma_done <= 1'b0;
      o_dma_addr <= 1'b0;
      o_dma_data <= 16'h0000;
    end else begin
      o_dma_we <= cnt == DELAY || cnt == DELAY + 1;
      o_dma_done <= cnt == DELAY + 2;
      o_dma_addr <= (cnt == DELAY || cnt == DELAY + 1) ? (cnt == DELAY + 1) : ~o_dma_addr;
      o_dma_data <= (cnt == DELAY) ? i_sin : (cnt == DELAY + 1) ? i_cos : ~o_dma_data;
      if (i_adc_trig) begin
        cnt <= 1;
      end else if (cnt > 0) begin
        cnt <= (cnt == DELAY + 2) ? 0 : cnt + 1;
      end
    end
  end
endmodule

// file: sim/pmsd_drive_sequencer_bench.sv
// Purpose: Self-checking bench for the drive sequencer over AHB-Lite.
// Assumes: Zero-wait slave; excitation period shortened to 100 cycles.
// Notes: Random currents, bus voltage and set-points from a fixed seed.
`timescale 1ns/1ps
module pmsd_drive_sequencer_bench;
  logic clk, rst, hsel, hwrite, hready, hresp, dsat, qsat, we, da, done, brake, exc, trig, vrun;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize, phi, plo;
  logic signed [15:0] ia, ib, ic, uq, iq, dd, tq;
  logic [15:0] udc, on_th, off_th;
  int num_errors, n_compared, k, hi_seen, req;
  int reqs[3];
  pmsd_drive_sequencer #(.EXC_CYCLES(100), .SPEED_RANGE(16'h1770)) DUT (.i_core_clk(clk), .i_sys_rst(rst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .i_ifilt_a(ia),
    .i_ifilt_b(ib), .i_ifilt_c(ic), .i_udc_filt(udc), .i_vcc_uq(uq), .i_iq_act(iq), .i_d_sat(dsat),
    .i_q_sat(qsat), .i_dma_we(we), .i_dma_addr(da), .i_dma_data(dd), .i_dma_done(done), .o_pwm_hi(phi),
    .o_pwm_lo(plo), .o_brake(brake), .o_excite(exc), .o_adc_trig(trig), .o_vcc_run(vrun), .o_torque_dem(tq));
  pmsd_resolver_model #(.DELAY(7)) partner (.i_core_clk(clk), .i_sys_rst(rst), .i_adc_trig(trig),
    .i_sin(16'sh0000), .i_cos(16'sh0000), .o_dma_we(we), .o_dma_addr(da), .o_dma_data(dd), .o_dma_done(done));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // A hung ready would otherwise stall the run forever, so every wait is bounded.
  task automatic wait_rdy();
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 16) begin
      k++;
      @(posedge clk);
    end
    if (k >= 16) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= v;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    v = hrdata;
  endtask
  function automatic logic [15:0] exp_th(input logic [15:0] u, input int pct);
    int v;
    v = u * pct / 100;
    return (v > 65535) ? 16'hffff : 16'(v);
  endfunction
  function automatic logic [15:0] exp_tq(input int r);
    return 16'(r * 32767 / 6000);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
  initial begin
    clk = 0;
    rst = 1;
    hsel = 1;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    ia = 0;
    ib = 0;
    ic = 0;
    udc = 0;
    uq = 0;
    iq = 0;
    dsat = 0;
    qsat = 0;
    void'($urandom(32'h1690));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0c, d);
    check(d, 32'h00006e82);
    rd(8'h10, d);
    check(d, 32'h00001001);
    rd(8'h3c, d);
    check(d, 32'h00000000);
    wr(8'h18, 32'h00000007);
    rd(8'h18, d);
    check(d, 32'h00000000);
    wr(8'h00, 32'h00000003);
    rd(8'h18, d);
    check(d, 32'h00000000);
    wr(8'h10, 32'h00001001);
    ia <= 16'($urandom);
    ib <= 16'($urandom);
    ic <= 16'($urandom);
    udc <= 16'($urandom_range(32'h7fff, 32'h1000));
    uq <= 16'($urandom);
    wr(8'h00, 32'h00000001);
    repeat (3) @(posedge clk);
    check({26'h0, phi, plo}, 32'h00000007);
    rd(8'h18, d);
    check(d, 32'h00000001);
    wr(8'h00, 32'h00000002);
    rd(8'h18, d);
    check(d, 32'h00000002);
    rd(8'h2c, d);
    check(d, {ib, ia});
    rd(8'h30, d);
    check(d, {16'h0000, ic});
    on_th = exp_th(udc, 130);
    off_th = exp_th(udc, 110);
    rd(8'h34, d);
    check(d, {off_th, on_th});
    udc <= on_th + 16'h0001;
    repeat (3) @(posedge clk);
    check({31'h0, brake}, 32'h00000001);
    rd(8'h18, d);
    check(d, 32'h00000102);
    udc <= off_th - 16'h0001;
    repeat (3) @(posedge clk);
    check({31'h0, brake}, 32'h00000000);
    wr(8'h04, {8'h00, 24'($urandom_range(32'h3fffff, 32'h100000))});
    wr(8'h00, 32'h00000003);
    rd(8'h18, d);
    check(d, 32'h00000003);
    hi_seen = 0;
    repeat (2600) begin
      @(posedge clk);
      if (phi !== 3'h0) begin
        hi_seen = 1;
      end
    end
    check(32'(hi_seen), 32'h00000001);
    check({31'h0, vrun}, 32'h00000000);
    wr(8'h00, 32'h00000004);
    rd(8'h18, d);
    check(d & 32'h0000000f, 32'h00000004);
    check({31'h0, vrun}, 32'h00000001);
    rd(8'h24, d);
    check(d, {16'h0000, uq});
    rd(8'h1c, d);
    check(d, 32'h00000000);
    rd(8'h28, d);
    check(d, 32'h00000000);
    check({31'h0, hresp}, 32'h00000000);
    reqs[0] = 32'h1770;
    reqs[1] = -32'sh1770;
    reqs[2] = $urandom_range(12000) - 6000;
    for (int i = 0; i < 3; i++) begin
      req = reqs[i];
      iq <= 16'($urandom);
      dsat <= 1'($urandom);
      qsat <= 1'($urandom);
      wr(8'h08, 32'(req));
      repeat (5100) @(posedge clk);
      check({16'h0000, tq}, {16'h0000, exp_tq(req)});
      rd(8'h20, d);
      check(d, {iq, exp_tq(req)});
      rd(8'h18, d);
      check({30'h0, d[7:6]}, {30'h0, qsat, dsat});
    end
    k = 0;
    while (trig !== 1'b1 && k < 300) begin
      k++;
      @(posedge clk);
    end
    hi_seen = int'(exc === 1'b1);
    k = 1;
    @(posedge clk);
    while (trig !== 1'b1 && k < 300) begin
      hi_seen += (exc === 1'b1);
      k++;
      @(posedge clk);
    end
    check(32'(k), 32'd100);
    check(32'(hi_seen), 32'd50);
    wr(8'h14, 32'd10);
    repeat (2) @(posedge clk);
    k = 0;
    while (trig !== 1'b1 && k < 300) begin
      k++;
      @(posedge clk);
    end
    k = 0;
    while (exc !== 1'b1 && k < 300) begin
      k++;
      @(posedge clk);
    end
    check(32'(k), 32'd10);
    wr(8'h00, 32'h00000005);
    repeat (3) @(posedge clk);
    rd(8'h18, d);
    check(d & 32'h00000007, 32'h00000000);
    check({25'h0, phi, plo, vrun}, 32'h00000000);
    check({16'h0000, tq}, 32'h00000000);
    wr(8'h00, 32'h00000001);
    wr(8'h00, 32'h00000002);
    wr(8'h00, 32'h00000003);
    wr(8'h00, 32'h00000104);
    rd(8'h18, d);
    check(d & 32'h0000000f, 32'h0000000c);
    wr(8'h00, 32'h00000005);
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule
